// >>> shared/phy_write_consts.vh
// Shared constants for the full-rate write-path PHY block
`ifndef PHY_WRITE_CONSTS_VH
`define PHY_WRITE_CONSTS_VH

// ==========================================================
// Register map (byte addresses, one 32-bit word each)
`define REG_CTRL_OFS 8'h00
`define REG_STAT_OFS 8'h04
`define REG_CFG_OFS 8'h08
`define REG_FREQ_OFS 8'h0c
`define REG_ADDR_W 8

// ==========================================================
// Control register fields and reset values
`define CTRL_DDR2_BIT 0
`define CTRL_CAS_LSB 4
`define CTRL_CAS_MSB 7
`define CTRL_DDR2_RST 1'h1

// ==========================================================
// Status register fields
`define STAT_WL_LSB 0
`define STAT_WL_MSB 3
`define STAT_CMD_DLY_BIT 4
`define STAT_TERM_DLY_BIT 5
`define STAT_DQ_OE_BIT 6
`define STAT_DQS_OE_BIT 7
`define STAT_WCNT_LSB 16
`define STAT_WCNT_MSB 31

// ==========================================================
// Memory command codes {ras_n, cas_n, we_n}
`define CMD_W 3
`define CMD_WRITE 3'h4
`define CMD_NOP 3'h7

// ==========================================================
// Extra-latency option codes and data-rate codes
`define LAT_FALSE 2'h0
`define LAT_TRUE 2'h1
`define LAT_RUNTIME 2'h2
`define RATE_FULL 1'h0
`define RATE_HALF 1'h1

// ==========================================================
// Fixed figures
`define DDR_WRITE_LAT 4'h1
`define CAS_TENTHS_PER_CYCLE 10
`define AHB_NONSEQ_BIT 1
`define AHB_OKAY 1'h0

`endif

// >>> logic/cmd_delay_stage.v
// Launch register with an optional extra memory cycle of delay
`timescale 1ns/1ps

module cmd_delay_stage #(
  parameter W = 8,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire tick,
  input wire add_cycle,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  // ==========================================================
  // Delay stages
  reg [W-1:0] hold_q;

  // Hold stage always tracks the input so switching the extra cycle on
  // mid-stream repeats only the last command once, never an older one
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_q <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else if (tick)
    begin
      hold_q <= din;
      dout <= add_cycle ? hold_q : din;
    end
  end

endmodule // cmd_delay_stage

// >>> logic/phy_fullrate_write.v
// Full-rate write path of a DDR/DDR2 PHY with AHB-Lite configuration registers
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "phy_write_consts.vh"

module phy_fullrate_write #(
  parameter DW = 8,
  parameter AW = 13,
  parameter PIPE_DEPTH = 8,
  parameter [1:0] cmd_extra_latency_cfg = `LAT_RUNTIME,
  parameter [1:0] term_extra_latency_cfg = `LAT_RUNTIME,
  parameter [0:0] datapath_rate_cfg = `RATE_FULL,
  parameter [8:0] memory_clock_freq_cfg = 9'd125,
  parameter [8:0] local_clock_freq_cfg = 9'd125,
  parameter [3:0] burst_length_cfg = 4'd4,
  parameter [7:0] cas_latency_cfg = 8'd30,
  parameter output_clock_pairs_cfg = 1
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire mem_clk_in,
  input wire [`CMD_W-1:0] ctl_cmd,
  input wire ctl_cs_n,
  input wire [AW-1:0] ctl_addr,
  input wire ctl_odt,
  input wire ctl_doing_wr,
  input wire ctl_wdata_valid,
  input wire ctl_dqs_burst,
  input wire [2*DW-1:0] ctl_wdata,
  input wire cmd_extra_latency_sel,
  input wire term_extra_latency_sel,
  output wire [`CMD_W-1:0] mem_cmd,
  output wire mem_cs_n,
  output wire [AW-1:0] mem_addr,
  output wire mem_odt,
  output reg [2*DW-1:0] mem_dq_out,
  output reg mem_dq_oe_n,
  output reg mem_dqs_out,
  output reg mem_dqs_oe_n,
  output reg [output_clock_pairs_cfg-1:0] mem_clk_p,
  output reg [output_clock_pairs_cfg-1:0] mem_clk_n
);

  // ==========================================================
  // Local widths and helpers
  localparam EW = 2 + 2 * DW;
  localparam CMDW = `CMD_W + 1 + AW;
  localparam [`CMD_W:0] CMD_IDLE = {`CMD_NOP, 1'b1};

  // Resolve a TRUE / FALSE / runtime option against its select input
  function extra_on;
    input [1:0] cfg;
    input sel;
    begin
      case (cfg)
        `LAT_TRUE: extra_on = 1'b1;
        `LAT_RUNTIME: extra_on = sel;
        default: extra_on = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // Memory clock edge detection
  reg mclk_s1_q;
  reg mclk_s2_q;
  reg mclk_s3_q;
  wire tick;

  // Two flops before use; the third only serves the edge detector
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mclk_s1_q <= 1'b0;
      mclk_s2_q <= 1'b0;
      mclk_s3_q <= 1'b0;
    end
    else
    begin
      mclk_s1_q <= mem_clk_in;
      mclk_s2_q <= mclk_s1_q;
      mclk_s3_q <= mclk_s2_q;
    end
  end

  // One memory cycle per rising edge of the sampled memory clock
  assign tick = mclk_s2_q & ~mclk_s3_q;

  // ==========================================================
  // Forwarded memory clock pairs
  genvar gi;
  generate
    for (gi = 0; gi < output_clock_pairs_cfg; gi = gi + 1)
    begin : g_clk_pair
      // Each pair is its own flop pair so outputs stay registered
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          mem_clk_p[gi] <= 1'b0;
          mem_clk_n[gi] <= 1'b1;
        end
        else
        begin
          mem_clk_p[gi] <= mclk_s2_q;
          mem_clk_n[gi] <= ~mclk_s2_q;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Configuration registers
  reg ddr2_q;
  reg [3:0] cas_q;
  reg [15:0] wcnt_q;
  wire [3:0] wr_lat;
  wire cmd_dly_on;
  wire term_dly_on;

  // Reset CAS in whole cycles; tenths are dropped, so 2.5 resets to 2
  localparam [31:0] CAS_RST_CYC = cas_latency_cfg / `CAS_TENTHS_PER_CYCLE;

  // DDR always writes one cycle after the command; DDR2 uses CL minus one when CL is above one
  assign wr_lat = (ddr2_q && cas_q > `DDR_WRITE_LAT) ? cas_q - `DDR_WRITE_LAT
                  : `DDR_WRITE_LAT;
  // Each path reads only its own option and select
  assign cmd_dly_on = extra_on(cmd_extra_latency_cfg, cmd_extra_latency_sel);
  assign term_dly_on = extra_on(term_extra_latency_cfg, term_extra_latency_sel);

  // ==========================================================
  // Command path with forced no-operation after each write
  reg last_write_q;
  wire issue_write;
  wire [`CMD_W-1:0] cmd_gated;
  wire cs_gated;
  wire [CMDW-1:0] cmd_word;
  wire [CMDW-1:0] cmd_out;

  // A write is a command only when chip select is active
  assign issue_write = (ctl_cmd == `CMD_WRITE) && !ctl_cs_n && !last_write_q;
  // Second cycle of a burst-four write is a no-operation with chip select idle
  assign cmd_gated = last_write_q ? `CMD_NOP : ctl_cmd;
  assign cs_gated = last_write_q ? 1'b1 : ctl_cs_n;
  assign cmd_word = {cmd_gated, cs_gated, ctl_addr};

  // Remember that the current memory cycle carried a write
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      last_write_q <= 1'b0;
    else if (tick)
      last_write_q <= issue_write;
  end

  // Command, chip select and address share one optional delay
  cmd_delay_stage #(
    .W(CMDW),
    .RESET_VAL({CMD_IDLE, {AW{1'b0}}})
  ) u_cmd_stage (
    .clk(hclk),
    .rst_n(hresetn),
    .tick(tick),
    .add_cycle(cmd_dly_on),
    .din(cmd_word),
    .dout(cmd_out)
  );

  assign mem_cmd = cmd_out[CMDW-1:AW+1];
  assign mem_cs_n = cmd_out[AW];
  assign mem_addr = cmd_out[AW-1:0];

  // Termination has a separate stage so its delay stays independent
  cmd_delay_stage #(
    .W(1),
    .RESET_VAL(1'b0)
  ) u_term_stage (
    .clk(hclk),
    .rst_n(hresetn),
    .tick(tick),
    .add_cycle(term_dly_on),
    .din(ctl_odt),
    .dout(mem_odt)
  );

  // ==========================================================
  // Write enable and data pipeline
  reg [EW-1:0] pipe_q [0:PIPE_DEPTH-1];
  wire [EW-1:0] pipe_in;
  wire [3:0] tap;
  wire [EW-1:0] tap_word;
  integer i;

  // Data valid drives only the data lanes; strobes run the whole burst
  assign pipe_in = {ctl_wdata_valid, ctl_doing_wr | ctl_dqs_burst, ctl_wdata};
  // Command delay shifts data by the same amount to keep write latency
  assign tap = wr_lat + {3'h0, cmd_dly_on} - 4'h1;
  assign tap_word = pipe_q[tap[2:0]];

  // Shift one entry per memory cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (i = 0; i < PIPE_DEPTH; i = i + 1)
        pipe_q[i] <= {EW{1'b0}};
    end
    else if (tick)
    begin
      pipe_q[0] <= pipe_in;
      for (i = 1; i < PIPE_DEPTH; i = i + 1)
        pipe_q[i] <= pipe_q[i-1];
    end
  end

  // Output enables are active low; both off until the burst starts
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_dq_oe_n <= 1'b1;
      mem_dqs_oe_n <= 1'b1;
      mem_dq_out <= {2*DW{1'b0}};
      mem_dqs_out <= 1'b0;
    end
    else if (tick)
    begin
      mem_dq_oe_n <= ~tap_word[EW-1];
      mem_dqs_oe_n <= ~tap_word[EW-2];
      mem_dq_out <= tap_word[2*DW-1:0];
      // Strobe toggles each memory cycle only while enabled
      mem_dqs_out <= tap_word[EW-2] ? ~mem_dqs_out : 1'b0;
    end
  end

  // ==========================================================
  // Write command counter, visible in status
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wcnt_q <= 16'h0000;
    else if (tick && issue_write)
      wcnt_q <= wcnt_q + 16'h0001;
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  reg wr_pend_q;
  reg [`REG_ADDR_W-1:0] wr_addr_q;
  reg [31:0] rd_word;
  wire addr_phase;

  // A transfer is taken only on NONSEQ or SEQ (htrans bit 1 set) with the bus ready
  assign addr_phase = hsel && hready && htrans[`AHB_NONSEQ_BIT];

  // Read multiplexer on the low eight address bits; unmapped offsets return zero
  always @*
  begin
    rd_word = 32'h00000000;
    case (haddr[`REG_ADDR_W-1:0])
      `REG_CTRL_OFS:
      begin
        rd_word[`CTRL_DDR2_BIT] = ddr2_q;
        rd_word[`CTRL_CAS_MSB:`CTRL_CAS_LSB] = cas_q;
      end
      `REG_STAT_OFS:
      begin
        rd_word[`STAT_WL_MSB:`STAT_WL_LSB] = wr_lat;
        rd_word[`STAT_CMD_DLY_BIT] = cmd_dly_on;
        rd_word[`STAT_TERM_DLY_BIT] = term_dly_on;
        rd_word[`STAT_DQ_OE_BIT] = ~mem_dq_oe_n;
        rd_word[`STAT_DQS_OE_BIT] = ~mem_dqs_oe_n;
        rd_word[`STAT_WCNT_MSB:`STAT_WCNT_LSB] = wcnt_q;
      end
      `REG_CFG_OFS:
      begin
        rd_word[0] = datapath_rate_cfg;
        rd_word[7:4] = burst_length_cfg;
        rd_word[12:8] = output_clock_pairs_cfg[4:0];
        rd_word[23:16] = cas_latency_cfg;
      end
      `REG_FREQ_OFS:
      begin
        rd_word[8:0] = memory_clock_freq_cfg;
        rd_word[24:16] = local_clock_freq_cfg;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read data registered in the address phase so it stands in the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= `AHB_OKAY;
      wr_pend_q <= 1'b0;
      wr_addr_q <= {`REG_ADDR_W{1'b0}};
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= `AHB_OKAY;
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase)
        wr_addr_q <= haddr[`REG_ADDR_W-1:0];
      if (addr_phase && !hwrite)
        hrdata <= rd_word;
    end
  end

  // Register write lands in the data phase, when hwdata is valid
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ddr2_q <= `CTRL_DDR2_RST;
      cas_q <= CAS_RST_CYC[3:0];
    end
    else if (wr_pend_q && wr_addr_q == `REG_CTRL_OFS)
    begin
      ddr2_q <= hwdata[`CTRL_DDR2_BIT];
      cas_q <= hwdata[`CTRL_CAS_MSB:`CTRL_CAS_LSB];
    end
  end

endmodule // phy_fullrate_write

// >>> dv/phy_write_checker.sv
// Port-level assertions for the full-rate write path
`timescale 1ns/1ps
`include "phy_write_consts.vh"
// ==========================================================
// Checker
module phy_write_checker #(
  parameter DW = 8,
  parameter output_clock_pairs_cfg = 1
) (
  input logic hclk,
  input logic hresetn,
  input logic hreadyout,
  input logic hresp,
  input logic [`CMD_W-1:0] mem_cmd,
  input logic mem_cs_n,
  input logic mem_odt,
  input logic [2*DW-1:0] mem_dq_out,
  input logic mem_dq_oe_n,
  input logic mem_dqs_out,
  input logic mem_dqs_oe_n,
  input logic [output_clock_pairs_cfg-1:0] mem_clk_p,
  input logic [output_clock_pairs_cfg-1:0] mem_clk_n
);
  logic wr;
  // Write command seen on the memory pins
  assign wr = (mem_cmd == `CMD_WRITE) && !mem_cs_n;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_reset_quiet: assert property (disable iff (1'b0)
    !hresetn |-> mem_cs_n && mem_dq_oe_n && mem_dqs_oe_n && !mem_odt)
    else $error("memory outputs active in reset");
  // A memory cycle is ten bus clocks, so a write stands ten and a no-op follows
  chk_write_then_nop: assert property ($rose(wr) |->
    wr[*8] ##3 (mem_cmd == `CMD_NOP && mem_cs_n)[*8])
    else $error("write not followed by no-op");
  chk_cs_one_cycle: assert property ($fell(mem_cs_n) |-> wr ##10 mem_cs_n)
    else $error("chip select not one write cycle");
  chk_dqs_covers_dq: assert property (!mem_dq_oe_n |-> !mem_dqs_oe_n)
    else $error("data enabled without strobe");
  chk_dqs_two_cycles: assert property ($fell(mem_dqs_oe_n) |->
    ##19 !mem_dqs_oe_n ##1 mem_dqs_oe_n)
    else $error("strobe burst not two cycles");
  // Strobe goes high on the first burst cycle and low on the second
  chk_dqs_toggles: assert property ($fell(mem_dqs_oe_n) |->
    mem_dqs_out ##10 !mem_dqs_out)
    else $error("strobe not toggling in burst");
  chk_write_latency: assert property ($rose(wr) |->
    (##10 $fell(mem_dq_oe_n)) or (##20 $fell(mem_dq_oe_n)))
    else $error("data not one or two cycles after write");
  chk_clock_pairs: assert property (mem_clk_n == ~mem_clk_p)
    else $error("clock pair not complementary");
  chk_ahb_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
  chk_dq_stands: assert property ($changed(mem_dq_out) |=> $stable(mem_dq_out)[*8])
    else $error("data changed inside a memory cycle");
  cover property ($rose(wr));
  cover property ($fell(mem_dq_oe_n));
  cover property (mem_dq_oe_n && !mem_dqs_oe_n);
endmodule // phy_write_checker

bind phy_fullrate_write phy_write_checker #(.DW(DW),
  .output_clock_pairs_cfg(output_clock_pairs_cfg)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .mem_cmd(mem_cmd),
  .mem_cs_n(mem_cs_n), .mem_odt(mem_odt), .mem_dq_out(mem_dq_out),
  .mem_dq_oe_n(mem_dq_oe_n), .mem_dqs_out(mem_dqs_out), .mem_dqs_oe_n(mem_dqs_oe_n),
  .mem_clk_p(mem_clk_p), .mem_clk_n(mem_clk_n));

// >>> dv/mem_ctl_model.sv
// Full-rate memory controller model driving the write side of the block
`timescale 1ns/1ps
`include "phy_write_consts.vh"
// ==========================================================
// Controller model
module mem_ctl_model (
  input logic hclk,
  input logic hresetn,
  input logic mem_clk_in,
  input logic start,
  input logic full,
  input logic b2b,
  input logic [31:0] data,
  input logic [12:0] addr,
  output logic busy,
  output logic [2:0] ctl_cmd,
  output logic ctl_cs_n,
  output logic [12:0] ctl_addr,
  output logic ctl_odt,
  output logic ctl_doing_wr,
  output logic ctl_wdata_valid,
  output logic ctl_dqs_burst,
  output logic [15:0] ctl_wdata
);
  logic mq;
  logic [1:0] st;
  logic w1;
  logic w2;
  assign busy = (st != 2'h0);
  assign w1 = (st == 2'h0) && start;
  assign w2 = (st == 2'h1);
  // Inputs move once per memory cycle, on the bus clock, well before the tick
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mq <= 1'b0;
      st <= 2'h0;
      ctl_cmd <= `CMD_NOP;
      ctl_cs_n <= 1'b1;
      {ctl_odt, ctl_doing_wr, ctl_wdata_valid, ctl_dqs_burst} <= 4'h0;
      ctl_addr <= 13'h0000;
      ctl_wdata <= 16'h0000;
    end
    else
    begin
      mq <= mem_clk_in;
      if (mem_clk_in && !mq)
      begin
        st <= (w1 || st != 2'h0) ? st + 2'h1 : st;
        // Back-to-back write is sent on purpose only when b2b is set
        ctl_cmd <= (w1 || (w2 && b2b)) ? `CMD_WRITE : `CMD_NOP;
        ctl_cs_n <= !(w1 || (w2 && b2b));
        ctl_odt <= w1;
        ctl_doing_wr <= w1 || (w2 && full);
        ctl_wdata_valid <= w1 || (w2 && full);
        ctl_dqs_burst <= w2;
        ctl_addr <= w1 ? addr : ~ctl_addr;
        // Idle data lines show no stale value
        ctl_wdata <= w1 ? data[15:0] : (w2 ? data[31:16] : ~ctl_wdata);
      end
    end
  end
endmodule // mem_ctl_model

// >>> dv/testbench.sv
// Self-checking bench for the full-rate write path
`timescale 1ns/1ps
`include "phy_write_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
// ==========================================================
// Top
module testbench;
  logic hclk = 0, hresetn = 1, mem_clk_in = 0, hsel = 0, hwrite = 0, csel = 0, tsel = 0;
  logic [31:0] haddr = 0, hwdata = 0, dat = 0, s = 32'h0001160c, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic start = 0, full = 0, b2b = 0, busy, ddv, dwr, dqb, odt, cs_n, mo, mq_n, ms_n;
  logic [12:0] adr = 0, ca, ma, am;
  logic [2:0] cc, mc;
  logic [15:0] cd, md, dq;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pc, pm, po, pq, ps;
  int err_total = 0, total_checks = 0, cyc = 0, tc, tm, to, tq0, tq1, ts0, ts1;
  logic [2:0] fc;
  logic fo, pf, pg;
  int tf, tg;
  logic [15:0] exp_q[$];
  phy_fullrate_write uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_clk_in(mem_clk_in),
    .ctl_cmd(cc), .ctl_cs_n(cs_n), .ctl_addr(ca), .ctl_odt(odt), .ctl_doing_wr(dwr),
    .ctl_wdata_valid(ddv), .ctl_dqs_burst(dqb), .ctl_wdata(cd),
    .cmd_extra_latency_sel(csel), .term_extra_latency_sel(tsel), .mem_cmd(mc),
    .mem_cs_n(), .mem_addr(ma), .mem_odt(mo), .mem_dq_out(md), .mem_dq_oe_n(mq_n),
    .mem_dqs_out(), .mem_dqs_oe_n(ms_n), .mem_clk_p(), .mem_clk_n());
  mem_ctl_model ctl (.hclk(hclk), .hresetn(hresetn), .mem_clk_in(mem_clk_in),
    .start(start), .full(full), .b2b(b2b), .data(dat), .addr(adr), .busy(busy),
    .ctl_cmd(cc), .ctl_cs_n(cs_n), .ctl_addr(ca), .ctl_odt(odt), .ctl_doing_wr(dwr),
    .ctl_wdata_valid(ddv), .ctl_dqs_burst(dqb), .ctl_wdata(cd));
  // Fixed options: command delay always on, termination never; selects driven opposite
  phy_fullrate_write #(.cmd_extra_latency_cfg(`LAT_TRUE),
    .term_extra_latency_cfg(`LAT_FALSE)) uut_fixed (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b0), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
    .mem_clk_in(mem_clk_in), .ctl_cmd(cc), .ctl_cs_n(cs_n), .ctl_addr(ca), .ctl_odt(odt),
    .ctl_doing_wr(dwr), .ctl_wdata_valid(ddv), .ctl_dqs_burst(dqb), .ctl_wdata(cd),
    .cmd_extra_latency_sel(~csel), .term_extra_latency_sel(~tsel), .mem_cmd(fc),
    .mem_cs_n(), .mem_addr(), .mem_odt(fo), .mem_dq_out(), .mem_dq_oe_n(),
    .mem_dqs_out(), .mem_dqs_oe_n(), .mem_clk_p(), .mem_clk_n());
  // Bus clock, and a memory clock with an unrelated phase
  initial forever #4 hclk = ~hclk;
  initial begin #3; forever #40 mem_clk_in = ~mem_clk_in; end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Edge times of controller and memory signals, in bus clocks
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    {pc, pm, po, pq, ps} <= {cc == `CMD_WRITE && !cs_n, mc == `CMD_WRITE, mo, mq_n, ms_n};
    if (cc == `CMD_WRITE && !cs_n && !pc) tc <= cyc;
    if (mc == `CMD_WRITE && !pm) begin tm <= cyc; am <= ma; end
    if (mo && !po) to <= cyc;
    if (!mq_n && pq) begin tq0 <= cyc; dq <= md; end
    if (mq_n && !pq) tq1 <= cyc;
    if (!ms_n && ps) ts0 <= cyc;
    if (ms_n && !ps) ts1 <= cyc;
    {pf, pg} <= {fc == `CMD_WRITE, fo};
    if (fc == `CMD_WRITE && !pf) tf <= cyc;
    if (fo && !pg) tg <= cyc;
  end
  // One bus cycle; waits end on hready or give up after a bound
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    r = hrdata;
    if (k >= 100) err_total++;
  endtask
  // One write burst through the controller model, checked against expectations
  task automatic run_op(input int i);
    int k, c0, wl;
    logic [15:0] ed;
    s = lfsr(s);
    exp_q.push_back(s[15:0]);
    wl = (i < 4) ? 2 : 1;
    {start, full, b2b, dat, adr} <= {1'b1, s[0], i == 3 || i == 6, s, s[28:16]};
    {csel, tsel} <= {i[0], i[1]};
    k = 0;
    do begin @(posedge hclk); k++; end while (busy !== 1'b1 && k < 100);
    start <= 1'b0;
    c0 = cyc;
    while (!(ts1 > c0) && k < 500) begin @(posedge hclk); k++; end
    if (k >= 500) err_total++;
    ed = exp_q.pop_front();
    `CHK("cmd_lat", i % 2, (tm - tc) / 10)
    `CHK("odt_lat", (i / 2) % 2, (to - tc) / 10)
    `CHK("wr_lat", wl, (tq0 - tm) / 10)
    `CHK("dq_len", s[0] ? 2 : 1, (tq1 - tq0) / 10)
    `CHK("dqs_len", 2, (ts1 - ts0) / 10)
    `CHK("dqs_start", tq0, ts0)
    `CHK("dq_data", ed, dq)
    `CHK("cmd_fixed", 1, (tf - tc) / 10)
    `CHK("odt_fixed", 0, (tg - tc) / 10)
    `CHK("addr", s[28:16], am)
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin #150000; err_total++; wrap_up(); end
  // Main sequence
  initial
  begin
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, `REG_CTRL_OFS, 0);
    `CHK("ctrl_rst", 32'h00000031, r)
    ahb(0, `REG_CFG_OFS, 0);
    `CHK("cfg", 32'h001e0140, r)
    ahb(0, `REG_FREQ_OFS, 0);
    `CHK("freq", 32'h007d007d, r)
    ahb(0, 32'h00000010, 0);
    `CHK("unmapped", 32'h00000000, r)
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4) ahb(1, `REG_CTRL_OFS, 32'h00000030);
      run_op(i);
    end
    ahb(0, `REG_CTRL_OFS, 0);
    `CHK("ctrl_ddr", 32'h00000030, r)
    ahb(0, `REG_STAT_OFS, 0);
    `CHK("writes", 16'h0008, r[31:16])
    `CHK("stat_flags", 8'h31, r[7:0])
    wrap_up();
  end
endmodule // testbench
